// ### core/rpg_gate.sv
// readout protection gate: mode capture, loader command gate and line framing
//
// Summary of operation
// - pin-block word stops entry pin sampling
// - level one: no debug, RAM write floor
// - level one: no copy to sector 0
// - level one: read and compare refused
// - level two: no debug, most commands refused
// - level two: only full erase and RPG_OP_OTHER accepted
// - level three: no debug, pin ignored if code
// - pin-block mode like three but pin ignored even without code, debug kept
// - refused commands answer the refusal code
// - no flash reads during erase or write
// - app programming owns top 32 SRAM bytes
// - app programming uses 128 stack bytes down
// - app programming never masks interrupts
// - surplus CR and LF between commands discarded
// - text responses end with CR then LF
// - payload bytes travel raw, not text
// - new word applies only after power cycle
// - app programming commands unrestricted once the mode is captured
`include "rpg_consts.svh"

module rpg_gate import rpg_pkg::*; #(
   parameter logic [3:0] LAST_SECTOR = `RPG_LAST_SECTOR,
   parameter logic [7:0] REFUSE_CODE = `RPG_CODE_REFUSE
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic warm_rst_i,
   output logic word_rd_req_o,
   output logic [31:0] word_rd_addr_o,
   input wire logic word_rd_ack_i,
   input wire logic [31:0] word_rd_data_i,
   input wire logic user_code_valid_i,
   output logic debug_en_o,
   output logic entry_pin_sample_en_o,
   output rpg_mode_e mode_o,
   input wire logic cmd_valid_i,
   input wire rpg_cmd_s cmd_i,
   output rpg_verdict_s verdict_o,
   input wire logic flash_busy_i,
   output logic flash_rd_en_o,
   input wire logic irq_en_i,
   output logic irq_en_o,
   input wire logic app_acc_valid_i,
   input wire logic [31:0] app_acc_addr_i,
   input wire logic [31:0] app_sp_i,
   output logic app_fault_o,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_binary_i,
   output rpg_char_s line_o,
   input wire logic resp_valid_i,
   input wire rpg_resp_s resp_i,
   output logic resp_ready_o,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   localparam rpg_state_s STATE_RST = '{
      boot: RPG_BOOT_FETCH,
      mode: RPG_MODE_NONE,
      debug_en: 1'b0,
      pin_en: 1'b0,
      verdict: '{valid: 1'b0, allow: 1'b0, code: `RPG_CODE_OK},
      flash_rd_en: 1'b0,
      irq_en: 1'b0,
      app_fault: 1'b0,
      in_line: 1'b0,
      line: '{valid: 1'b0, eol: 1'b0, data: 8'h00},
      tx: RPG_TX_DATA,
      tx_valid: 1'b0,
      tx_data: 8'h00,
      resp_ready: 1'b0
   };

   rpg_state_s s_r;
   rpg_state_s s_nxt;
   rpg_mode_e word_mode;
   logic run;
   logic refuse;
   logic all_sectors;
   logic is_eol_char;
   logic in_work;
   logic in_stack;
   logic [31:0] stack_floor;
   logic tx_take;
   logic slot_free;

   rpg_mode_decode u_decode (
      .prot_word_i(word_rd_data_i),
      .mode_o(word_mode)
   );

   assign run = (s_r.boot == RPG_BOOT_RUN);
   assign all_sectors = (cmd_i.start_sec == 4'h0) && (cmd_i.end_sec == LAST_SECTOR);
   assign is_eol_char = (rx_data_i == `RPG_CHAR_CR) || (rx_data_i == `RPG_CHAR_LF);
   assign stack_floor = app_sp_i - `RPG_STACK_BYTES;
   assign in_work = (app_acc_addr_i >= `RPG_WORK_LO) && (app_acc_addr_i <= `RPG_WORK_HI);
   assign in_stack = (app_acc_addr_i < app_sp_i) && (app_acc_addr_i >= stack_floor);
   assign tx_take = s_r.tx_valid && tx_ready_i;
   assign slot_free = !s_r.tx_valid || tx_take;

   ////////////////////////////////////////////////////////////////////////////
   // command gate

   always_comb begin
      refuse = 1'b0;
      if (!run) begin
         // mode unknown until the word is in: stay closed
         refuse = 1'b1;
      end else if (!cmd_i.app_src) begin
         case (s_r.mode)
            RPG_MODE_L1: begin
               case (cmd_i.op)
                  RPG_OP_READ: refuse = 1'b1;
                  RPG_OP_COMPARE: refuse = 1'b1;
                  RPG_OP_WRITE_RAM: refuse = (cmd_i.addr < `RPG_RAM_LIMIT);
                  RPG_OP_COPY: refuse = (cmd_i.addr <= `RPG_SECTOR0_END);
                  RPG_OP_ERASE: refuse = (cmd_i.start_sec == 4'h0) && !all_sectors;
                  default: refuse = 1'b0;
               endcase
            end
            RPG_MODE_L2: begin
               case (cmd_i.op)
                  RPG_OP_READ: refuse = 1'b1;
                  RPG_OP_WRITE_RAM: refuse = 1'b1;
                  RPG_OP_GO: refuse = 1'b1;
                  RPG_OP_COPY: refuse = 1'b1;
                  RPG_OP_COMPARE: refuse = 1'b1;
                  RPG_OP_ERASE: refuse = !all_sectors;
                  default: refuse = 1'b0;
               endcase
            end
            default: refuse = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_nxt = s_r;

      // word is taken once per power-on; warm reset keeps it
      case (s_r.boot)
         RPG_BOOT_FETCH: begin
            if (word_rd_ack_i) begin
               s_nxt.mode = word_mode;
               s_nxt.boot = RPG_BOOT_RUN;
            end
         end
         RPG_BOOT_RUN: s_nxt.boot = RPG_BOOT_RUN;
         default: s_nxt.boot = RPG_BOOT_FETCH;
      endcase

      s_nxt.debug_en = run && (s_r.mode != RPG_MODE_L1) && (s_r.mode != RPG_MODE_L2)
         && (s_r.mode != RPG_MODE_L3);
      s_nxt.pin_en = run && (s_r.mode != RPG_MODE_PINBLK)
         && !((s_r.mode == RPG_MODE_L3) && user_code_valid_i);

      s_nxt.verdict.valid = cmd_valid_i && !warm_rst_i;
      s_nxt.verdict.allow = cmd_valid_i && !refuse;
      s_nxt.verdict.code = (cmd_valid_i && refuse) ? REFUSE_CODE : `RPG_CODE_OK;

      s_nxt.flash_rd_en = !flash_busy_i;
      // the gate passes the interrupt enable through and never drops it
      s_nxt.irq_en = irq_en_i;
      s_nxt.app_fault = app_acc_valid_i && !in_work && !in_stack;

      // receive side: command text and raw payload
      s_nxt.line.valid = 1'b0;
      s_nxt.line.eol = 1'b0;
      if (rx_valid_i) begin
         if (rx_binary_i) begin
            s_nxt.line.valid = 1'b1;
            s_nxt.line.data = rx_data_i;
         end else if (is_eol_char) begin
            // first CR or LF closes the line, the rest fall away
            s_nxt.line.eol = s_r.in_line;
            s_nxt.in_line = 1'b0;
         end else begin
            s_nxt.line.valid = 1'b1;
            s_nxt.line.data = rx_data_i;
            s_nxt.in_line = 1'b1;
         end
      end

      // transmit side: one byte slot, CR LF appended after text
      if (tx_take) begin
         s_nxt.tx_valid = 1'b0;
      end
      case (s_r.tx)
         RPG_TX_DATA: begin
            if (s_r.resp_ready && resp_valid_i) begin
               s_nxt.tx_valid = 1'b1;
               s_nxt.tx_data = resp_i.data;
               if (resp_i.last && !resp_i.bin) begin
                  s_nxt.tx = RPG_TX_CR;
               end
            end
         end
         RPG_TX_CR: begin
            if (slot_free) begin
               s_nxt.tx_valid = 1'b1;
               s_nxt.tx_data = `RPG_CHAR_CR;
               s_nxt.tx = RPG_TX_LF;
            end
         end
         RPG_TX_LF: begin
            if (slot_free) begin
               s_nxt.tx_valid = 1'b1;
               s_nxt.tx_data = `RPG_CHAR_LF;
               s_nxt.tx = RPG_TX_DATA;
            end
         end
         default: s_nxt.tx = RPG_TX_DATA;
      endcase
      // half rate on text, but the slot is always empty when a byte lands
      s_nxt.resp_ready = (s_nxt.tx == RPG_TX_DATA) && !s_nxt.tx_valid;

      if (warm_rst_i) begin
         s_nxt.in_line = 1'b0;
         s_nxt.line = '0;
         s_nxt.tx = RPG_TX_DATA;
         s_nxt.tx_valid = 1'b0;
         s_nxt.resp_ready = 1'b0;
         s_nxt.verdict = '0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_r <= STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign word_rd_req_o = s_r.boot[0]; // one-hot: bit 0 is the fetch state
   assign word_rd_addr_o = `RPG_WORD_OFFSET;
   assign debug_en_o = s_r.debug_en;
   assign entry_pin_sample_en_o = s_r.pin_en;
   assign mode_o = s_r.mode;
   assign verdict_o = s_r.verdict;
   assign flash_rd_en_o = s_r.flash_rd_en;
   assign irq_en_o = s_r.irq_en;
   assign app_fault_o = s_r.app_fault;
   assign line_o = s_r.line;
   assign resp_ready_o = s_r.resp_ready;
   assign tx_valid_o = s_r.tx_valid;
   assign tx_data_o = s_r.tx_data;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);

   logic host_cmd;
   assign host_cmd = cmd_valid_i && !cmd_i.app_src && !warm_rst_i && run;

   property p_pinblk_pin;
      run && (s_r.mode == RPG_MODE_PINBLK) |=> !entry_pin_sample_en_o;
   endproperty
   a_pinblk_pin: assert property (p_pinblk_pin) else $error("pin sampled in pin-block mode");

   property p_l1_ram_floor;
      host_cmd && (s_r.mode == RPG_MODE_L1) && (cmd_i.op == RPG_OP_WRITE_RAM)
         && (cmd_i.addr < `RPG_RAM_LIMIT) |=> verdict_o.valid && !verdict_o.allow;
   endproperty
   a_l1_ram_floor: assert property (p_l1_ram_floor) else $error("low RAM write allowed");

   property p_l1_copy;
      host_cmd && (s_r.mode == RPG_MODE_L1) && (cmd_i.op == RPG_OP_COPY)
         |=> verdict_o.allow == ($past(cmd_i.addr) > `RPG_SECTOR0_END);
   endproperty
   a_l1_copy: assert property (p_l1_copy) else $error("copy verdict wrong at level one");

   property p_l1_read;
      host_cmd && (s_r.mode == RPG_MODE_L1)
         && ((cmd_i.op == RPG_OP_READ) || (cmd_i.op == RPG_OP_COMPARE)) |=> !verdict_o.allow;
   endproperty
   a_l1_read: assert property (p_l1_read) else $error("read or compare allowed");

   property p_l2_go;
      host_cmd && (s_r.mode == RPG_MODE_L2) && (cmd_i.op == RPG_OP_GO) |=> !verdict_o.allow;
   endproperty
   a_l2_go: assert property (p_l2_go) else $error("go allowed at level two");

   property p_l2_erase;
      host_cmd && (s_r.mode == RPG_MODE_L2) && (cmd_i.op == RPG_OP_ERASE)
         |=> verdict_o.allow == $past(all_sectors);
   endproperty
   a_l2_erase: assert property (p_l2_erase) else $error("erase verdict wrong at level two");

   property p_locked_debug;
      run && ((s_r.mode == RPG_MODE_L1) || (s_r.mode == RPG_MODE_L2)
         || (s_r.mode == RPG_MODE_L3)) |=> !debug_en_o [*2];
   endproperty
   a_locked_debug: assert property (p_locked_debug) else $error("debug open while locked");

   property p_pinblk_debug;
      run && (s_r.mode == RPG_MODE_PINBLK) |=> debug_en_o;
   endproperty
   a_pinblk_debug: assert property (p_pinblk_debug) else $error("debug closed");

   property p_refuse_code;
      verdict_o.valid && !verdict_o.allow |-> verdict_o.code == REFUSE_CODE;
   endproperty
   a_refuse_code: assert property (p_refuse_code) else $error("refusal code missing");

   property p_flash_busy;
      flash_busy_i |=> !flash_rd_en_o;
   endproperty
   a_flash_busy: assert property (p_flash_busy) else $error("flash readable while busy");

   property p_work_ok;
      app_acc_valid_i && in_work |=> !app_fault_o;
   endproperty
   a_work_ok: assert property (p_work_ok) else $error("work area access flagged");

   property p_lf_after_cr;
      tx_take && (s_r.tx == RPG_TX_LF) && (tx_data_o == `RPG_CHAR_CR) && !warm_rst_i
         |=> tx_valid_o && (tx_data_o == `RPG_CHAR_LF);
   endproperty
   a_lf_after_cr: assert property (p_lf_after_cr) else $error("CR not followed by LF");

   property p_mode_held;
      run |=> $stable(mode_o) && run;
   endproperty
   a_mode_held: assert property (p_mode_held) else $error("mode changed after capture");

   property p_app_free;
      cmd_valid_i && cmd_i.app_src && run && !warm_rst_i |=> verdict_o.allow;
   endproperty
   a_app_free: assert property (p_app_free) else $error("app command refused");

   c_l1_refuse: cover property (host_cmd && (s_r.mode == RPG_MODE_L1) ##1 !verdict_o.allow);
   c_l2_full_erase: cover property (host_cmd && (s_r.mode == RPG_MODE_L2)
      && (cmd_i.op == RPG_OP_ERASE) ##1 verdict_o.allow);
   c_line_end: cover property (line_o.eol);
   c_resp_crlf: cover property (tx_valid_o && (tx_data_o == `RPG_CHAR_LF) && tx_ready_i);

endmodule // rpg_gate

// ### core/rpg_mode_decode.sv
// decodes the stored protection word into a protection mode
`include "rpg_consts.svh"

module rpg_mode_decode import rpg_pkg::*; (
   input wire logic [31:0] prot_word_i,
   output rpg_mode_e mode_o
);

   always_comb begin
      case (prot_word_i)
         `RPG_PAT_PINBLK: mode_o = RPG_MODE_PINBLK;
         `RPG_PAT_L1: mode_o = RPG_MODE_L1;
         `RPG_PAT_L2: mode_o = RPG_MODE_L2;
         `RPG_PAT_L3: mode_o = RPG_MODE_L3;
         // any other pattern leaves the part open
         default: mode_o = RPG_MODE_NONE;
      endcase
   end

endmodule // rpg_mode_decode

// ### shared/rpg_consts.svh
// constants of the readout protection gate
`ifndef RPG_CONSTS_SVH
`define RPG_CONSTS_SVH

// protection word location and patterns
`define RPG_WORD_OFFSET 32'h0000_02FC
`define RPG_PAT_PINBLK 32'h4E69_7370
`define RPG_PAT_L1 32'h1234_5678
`define RPG_PAT_L2 32'h8765_4321
`define RPG_PAT_L3 32'h4321_8765

// address limits
`define RPG_RAM_LIMIT 32'h2000_0300
`define RPG_SECTOR0_END 32'h0000_7FFF
`define RPG_WORK_LO 32'h2000_FFE0
`define RPG_WORK_HI 32'h2000_FFFF
`define RPG_STACK_BYTES 32'h0000_0080
`define RPG_LAST_SECTOR 4'h7

// framing characters and answer codes
`define RPG_CHAR_CR 8'h0D
`define RPG_CHAR_LF 8'h0A
`define RPG_CODE_OK 8'h00
`define RPG_CODE_REFUSE 8'hFF

`endif

// ### shared/rpg_pkg.sv
// types of the readout protection gate
package rpg_pkg;

   typedef enum logic [4:0] {
      RPG_MODE_NONE = 5'h01,
      RPG_MODE_L1 = 5'h02,
      RPG_MODE_L2 = 5'h04,
      RPG_MODE_L3 = 5'h08,
      RPG_MODE_PINBLK = 5'h10
   } rpg_mode_e;

   typedef enum logic [2:0] {
      RPG_OP_READ = 3'h0,
      RPG_OP_WRITE_RAM = 3'h1,
      RPG_OP_GO = 3'h2,
      RPG_OP_COPY = 3'h3,
      RPG_OP_COMPARE = 3'h4,
      RPG_OP_ERASE = 3'h5,
      RPG_OP_OTHER = 3'h6
   } rpg_op_e;

   typedef enum logic [1:0] {
      RPG_BOOT_FETCH = 2'h1,
      RPG_BOOT_RUN = 2'h2
   } rpg_boot_e;

   typedef enum logic [2:0] {
      RPG_TX_DATA = 3'h1,
      RPG_TX_CR = 3'h2,
      RPG_TX_LF = 3'h4
   } rpg_tx_e;

   typedef struct packed {
      rpg_op_e op;
      logic [31:0] addr;
      logic [3:0] start_sec;
      logic [3:0] end_sec;
      logic app_src;
   } rpg_cmd_s;

   typedef struct packed {
      logic valid;
      logic allow;
      logic [7:0] code;
   } rpg_verdict_s;

   typedef struct packed {
      logic valid;
      logic eol;
      logic [7:0] data;
   } rpg_char_s;

   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic bin;
   } rpg_resp_s;

   typedef struct packed {
      rpg_boot_e boot;
      rpg_mode_e mode;
      logic debug_en;
      logic pin_en;
      rpg_verdict_s verdict;
      logic flash_rd_en;
      logic irq_en;
      logic app_fault;
      logic in_line;
      rpg_char_s line;
      rpg_tx_e tx;
      logic tx_valid;
      logic [7:0] tx_data;
      logic resp_ready;
   } rpg_state_s;

endpackage

// ### testbench/rpg_host_model.sv
// far side model: protection word source and response byte sink
module rpg_host_model #(
   parameter int STALL = 3
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [31:0] word_i,
   input wire logic [7:0] delay_i,
   input wire logic word_rd_req_i,
   output logic word_rd_ack_o,
   output logic [31:0] word_rd_data_o,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int tick = 0;
   logic [7:0] rx_q [$];
   // released data lines show the inverse, never a stale copy
   assign word_rd_data_o = word_rd_ack_o ? word_i : ~word_i;
   initial begin
      word_rd_ack_o = 1'b0;
      tx_ready_o = 1'b0;
   end
   always @(negedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt = 0;
         word_rd_ack_o = 1'b0;
      end else begin
         word_rd_ack_o = word_rd_req_i && !word_rd_ack_o && cnt >= int'(delay_i);
         cnt = word_rd_req_i ? cnt + 1 : 0;
      end
   end
   // stalls every few cycles so held bytes get exercised
   always @(negedge clk_i) begin
      tick = tick + 1;
      tx_ready_o = (tick % STALL) != 0;
   end
   always @(posedge clk_i) begin
      if (arst_n_i && tx_valid_i && tx_ready_o) begin
         rx_q.push_back(tx_data_i);
      end
   end
endmodule // rpg_host_model

// ### testbench/tb_readout_protection_gate.sv
// self-checking testbench of the readout protection gate
`include "rpg_consts.svh"

module tb_readout_protection_gate import rpg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, arst_n_i = 1'b0, warm_rst_i = 1'b0, word_rd_req_o, word_rd_ack_i;
   logic [31:0] word_rd_addr_o, word_rd_data_i, app_acc_addr_i = '0, word = '0;
   logic [31:0] app_sp_i = 32'h2000_8000;
   logic user_code_valid_i = 1'b0, debug_en_o, entry_pin_sample_en_o, cmd_valid_i = 1'b0;
   logic flash_busy_i = 1'b0, flash_rd_en_o, irq_en_i = 1'b0, irq_en_o, app_acc_valid_i = 1'b0;
   logic app_fault_o, rx_valid_i = 1'b0, rx_binary_i = 1'b0, resp_valid_i = 1'b0;
   logic resp_ready_o, tx_valid_o, tx_ready_i;
   logic [7:0] rx_data_i = '0, tx_data_o, delay = '0;
   rpg_mode_e mode_o;
   rpg_cmd_s cmd_i = '0;
   rpg_verdict_s verdict_o;
   rpg_char_s line_o;
   rpg_resp_s resp_i = '0;
   int n_fail = 0, samples_checked = 0, seed = 32'h4e8e;
   logic [7:0] exp_q [$];

   always #2.5 clk_i = ~clk_i;

   rpg_gate i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .warm_rst_i(warm_rst_i),
      .word_rd_req_o(word_rd_req_o), .word_rd_addr_o(word_rd_addr_o),
      .word_rd_ack_i(word_rd_ack_i), .word_rd_data_i(word_rd_data_i),
      .user_code_valid_i(user_code_valid_i), .debug_en_o(debug_en_o),
      .entry_pin_sample_en_o(entry_pin_sample_en_o), .mode_o(mode_o),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .verdict_o(verdict_o),
      .flash_busy_i(flash_busy_i), .flash_rd_en_o(flash_rd_en_o), .irq_en_i(irq_en_i),
      .irq_en_o(irq_en_o), .app_acc_valid_i(app_acc_valid_i), .app_acc_addr_i(app_acc_addr_i),
      .app_sp_i(app_sp_i), .app_fault_o(app_fault_o), .rx_valid_i(rx_valid_i),
      .rx_data_i(rx_data_i), .rx_binary_i(rx_binary_i), .line_o(line_o),
      .resp_valid_i(resp_valid_i), .resp_i(resp_i), .resp_ready_o(resp_ready_o),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));

   rpg_host_model i_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .word_i(word), .delay_i(delay),
      .word_rd_req_i(word_rd_req_o), .word_rd_ack_o(word_rd_ack_i),
      .word_rd_data_o(word_rd_data_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_ready_o(tx_ready_i));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic logic allow_f(rpg_mode_e m, rpg_cmd_s c);
      logic all_sec;
      all_sec = c.start_sec == 4'h0 && c.end_sec == `RPG_LAST_SECTOR;
      if (c.app_src) return 1'b1;
      if (m == RPG_MODE_L1) begin
         case (c.op)
            RPG_OP_READ, RPG_OP_COMPARE: return 1'b0;
            RPG_OP_WRITE_RAM: return c.addr >= `RPG_RAM_LIMIT;
            RPG_OP_COPY: return c.addr > `RPG_SECTOR0_END;
            RPG_OP_ERASE: return c.start_sec != 4'h0 || all_sec;
            default: return 1'b1;
         endcase
      end
      if (m == RPG_MODE_L2) return c.op == RPG_OP_OTHER || (c.op == RPG_OP_ERASE && all_sec);
      return 1'b1;
   endfunction

   function automatic rpg_cmd_s rand_cmd();
      rpg_cmd_s c;
      logic [31:0] corner [4];
      corner = '{`RPG_RAM_LIMIT - 32'h1, `RPG_RAM_LIMIT, `RPG_SECTOR0_END,
         `RPG_SECTOR0_END + 32'h1};
      c.op = rpg_op_e'(3'({$random(seed)} % 7));
      c.addr = ($random(seed) & 1) ? corner[{$random(seed)} % 4] : $random(seed);
      c.start_sec = ($random(seed) & 1) ? 4'h0 : 4'({$random(seed)} % 8);
      c.end_sec = ($random(seed) & 1) ? `RPG_LAST_SECTOR : 4'({$random(seed)} % 8);
      c.app_src = ($random(seed) & 7) == 0;
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // random commands and app accesses in about half the cycles, busy and irq every cycle, each checked one cycle on
   task automatic run_cmds(input int n, input rpg_mode_e m);
      logic pv, pb, pi, pf;
      rpg_cmd_s pc;
      pv = 1'b0;
      pb = flash_busy_i;
      pi = irq_en_i;
      pf = 1'b0;
      pc = '0;
      for (int i = 0; i <= n; i++) begin
         @(negedge clk_i);
         check("verdict valid", verdict_o.valid, pv);
         if (pv) check("verdict allow", verdict_o.allow,
            allow_f(m, pc));
         if (pv) check("verdict code", verdict_o.code,
            allow_f(m, pc) ? `RPG_CODE_OK : `RPG_CODE_REFUSE);
         check("flash read enable", flash_rd_en_o, !pb);
         check("irq enable", irq_en_o, pi);
         check("app fault", app_fault_o, pf);
         pc = rand_cmd();
         pv = (i < n) && ($random(seed) & 1);
         cmd_i = pc;
         cmd_valid_i = pv;
         pb = 1'($random(seed));
         pi = 1'($random(seed));
         flash_busy_i = pb;
         irq_en_i = pi;
         // range reaches past both ends of each window
         app_acc_addr_i = (($random(seed) & 1) ? `RPG_WORK_LO : app_sp_i - `RPG_STACK_BYTES)
            + 32'($random(seed) % 160);
         app_acc_valid_i = (i < n) && ($random(seed) & 1);
         pf = app_acc_valid_i && !(app_acc_addr_i >= `RPG_WORK_LO && app_acc_addr_i <= `RPG_WORK_HI)
            && !(app_acc_addr_i >= app_sp_i - `RPG_STACK_BYTES && app_acc_addr_i < app_sp_i);
      end
   endtask

   task automatic run_rx(input int n);
      logic in_line, ev, ee, crlf;
      logic [7:0] d;
      in_line = 1'b0;
      ev = 1'b0;
      ee = 1'b0;
      d = '0;
      for (int i = 0; i <= n; i++) begin
         @(negedge clk_i);
         check("line char", line_o.valid, ev);
         check("line end", line_o.eol, ee);
         if (ev) check("line data", line_o.data, d);
         rx_binary_i = ($random(seed) & 7) == 0;
         case ($random(seed) & 3)
            0: d = `RPG_CHAR_CR;
            1: d = `RPG_CHAR_LF;
            default: d = 8'h41 + 8'($random(seed) & 15);
         endcase
         crlf = d == `RPG_CHAR_CR || d == `RPG_CHAR_LF;
         ev = (i < n) && (rx_binary_i || !crlf);
         ee = (i < n) && !rx_binary_i && crlf && in_line;
         if (i < n && !rx_binary_i) in_line = !crlf;
         rx_data_i = d;
         rx_valid_i = i < n;
      end
   endtask

   task automatic send_resp(input logic [7:0] d, input logic last, input logic bin);
      int k;
      k = 0;
      @(negedge clk_i);
      while (!resp_ready_o && k < 50) begin
         @(negedge clk_i);
         k++;
      end
      check("response ready", resp_ready_o, 1'b1);
      resp_i = '{data: d, last: last, bin: bin};
      resp_valid_i = 1'b1;
      @(negedge clk_i);
      resp_valid_i = 1'b0;
      exp_q.push_back(d);
      if (last && !bin) exp_q.push_back(`RPG_CHAR_CR);
      if (last && !bin) exp_q.push_back(`RPG_CHAR_LF);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (30000) @(posedge clk_i);
      n_fail++;
      summarize();
   end

   initial begin
      logic [31:0] words [5];
      rpg_mode_e md [5];
      md = '{RPG_MODE_NONE, RPG_MODE_L1, RPG_MODE_L2, RPG_MODE_L3, RPG_MODE_PINBLK};
      words = '{32'h0, `RPG_PAT_L1, `RPG_PAT_L2, `RPG_PAT_L3, `RPG_PAT_PINBLK};
      words[0] = $random(seed);
      for (int i = 0; i < 5; i++) begin
         // power cycle: the only way a new word is taken
         arst_n_i = 1'b0;
         word = words[i];
         delay = 8'(i * 3);
         repeat (10) @(negedge clk_i);
         check("word address", word_rd_addr_o, `RPG_WORD_OFFSET);
         arst_n_i = 1'b1;
         if (i > 0) begin
            @(negedge clk_i);
            cmd_i = '{op: RPG_OP_GO, addr: 32'h0, start_sec: 4'h0, end_sec: 4'h0, app_src: 1'b1};
            cmd_valid_i = 1'b1;
            @(negedge clk_i);
            cmd_valid_i = 1'b0;
            check("early code", verdict_o.code, `RPG_CODE_REFUSE);
         end
         for (int k = 0; k < 50 && word_rd_req_o; k++) @(negedge clk_i);
         user_code_valid_i = 1'b0;
         @(negedge clk_i);
         check("mode", mode_o, md[i]);
         check("debug", debug_en_o,
            !(md[i] inside {RPG_MODE_L1, RPG_MODE_L2, RPG_MODE_L3}));
         check("pin sample", entry_pin_sample_en_o, md[i] != RPG_MODE_PINBLK);
         user_code_valid_i = 1'b1;
         @(negedge clk_i);
         check("pin sample code", entry_pin_sample_en_o,
            !(md[i] inside {RPG_MODE_L3, RPG_MODE_PINBLK}));
         run_cmds(150, md[i]);
         word = words[(i + 1) % 5];
         // a command that meets warm reset gets no verdict
         warm_rst_i = 1'b1;
         cmd_valid_i = 1'b1;
         @(negedge clk_i);
         warm_rst_i = 1'b0;
         cmd_valid_i = 1'b0;
         check("verdict in warm reset", verdict_o.valid, 1'b0);
         repeat (3) @(negedge clk_i);
         check("mode after warm reset", mode_o, md[i]);
         check("no refetch", word_rd_req_o, 1'b0);
         $display("test protection mode %0d done", i);
      end
      run_rx(120);
      $display("test line framing done");
      send_resp(8'h4F, 1'b0, 1'b0);
      send_resp(8'h4B, 1'b1, 1'b0);
      for (int i = 0; i < 3; i++) send_resp(8'($random(seed)), i == 2, 1'b1);
      send_resp(8'h30, 1'b1, 1'b0);
      repeat (40) @(negedge clk_i);
      check("tx count", i_host.rx_q.size(), exp_q.size());
      for (int i = 0; i < exp_q.size() && i < i_host.rx_q.size(); i++) begin
         check("tx byte", i_host.rx_q[i], exp_q[i]);
      end
      $display("test response framing done");
      summarize();
   end
endmodule // tb_readout_protection_gate
